// *** verilog/cwt_pkg.sv ***
// Constants, types and lookups shared by the cyclic wake timer block
package cwt_pkg;
  // Register addresses on the serial register port
  localparam logic [6:0]  CWT_ADDR_TCTRL  = 7'h06;
  localparam logic [6:0]  CWT_ADDR_MASK   = 7'h09;
  localparam logic [15:0] CWT_TCTRL_RST   = 16'h0000;
  localparam logic [15:0] CWT_MASK_RST    = 16'h0140;
  // Readable bits; zeros mark read-as-zero positions
  localparam logic [15:0] CWT_TCTRL_RMASK = 16'hEFF7;
  localparam logic [15:0] CWT_MASK_RMASK  = 16'h01FF;
  // Timer register field positions
  localparam int CWT_T2_ON_LSB  = 13;
  localparam int CWT_T2_PER_LSB = 9;
  localparam int CWT_WAKE_LSB   = 7;
  localparam int CWT_T1_ON_LSB  = 4;
  localparam int CWT_T1_PER_LSB = 0;
  // Mask register bit positions
  localparam int CWT_M_PERIODIC = 8;
  localparam int CWT_M_WDOFF    = 7;
  localparam int CWT_M_WDFAIL   = 6;
  localparam int CWT_M_FRAME    = 5;
  localparam int CWT_M_BRIDGE   = 4;
  localparam int CWT_M_TEMP     = 1;
  localparam int CWT_M_SUPPLY   = 0;
  // Timing
  localparam int CWT_CLK_NS          = 8;
  localparam int CWT_TICK_NS         = 100000;
  localparam int CWT_TICK_CYCLES     = CWT_TICK_NS / CWT_CLK_NS;
  localparam int CWT_IRQ_PULSE_NS    = 1000;
  localparam int CWT_IRQ_PULSE_CYC   = (CWT_IRQ_PULSE_NS + CWT_CLK_NS - 1) / CWT_CLK_NS;
  localparam int CWT_PERIODIC_NS     = 10000000;
  localparam int CWT_PERIODIC_CYCLES = CWT_PERIODIC_NS / CWT_CLK_NS;

  typedef enum logic [1:0] {
    CWT_WAKE_NONE = 2'b00,
    CWT_WAKE_T1   = 2'b01,
    CWT_WAKE_T2   = 2'b10,
    CWT_WAKE_RSVD = 2'b11
  } cwt_wake_e;

  typedef struct packed {
    logic [2:0] on_code;
    logic [2:0] per_code;
  } cwt_tmr_cfg_s;

  typedef struct packed {
    logic wd_fail;
    logic frame_fail;
    logic crc_fail;
    logic bridge;
    logic temp;
    logic supply;
  } cwt_evt_s;

  // On-time in 0.1 ms ticks; zero means off or reserved
  function automatic logic [14:0] cwt_on_ticks(input logic [2:0] code);
    case (code)
      3'h1:    cwt_on_ticks = 15'h0001;
      3'h2:    cwt_on_ticks = 15'h0003;
      3'h3:    cwt_on_ticks = 15'h000A;
      3'h4:    cwt_on_ticks = 15'h0064;
      3'h5:    cwt_on_ticks = 15'h00C8;
      default: cwt_on_ticks = 15'h0000;
    endcase
  endfunction

  // Period in 0.1 ms ticks
  function automatic logic [14:0] cwt_per_ticks(input logic [2:0] code);
    case (code)
      3'h0:    cwt_per_ticks = 15'h0064;
      3'h1:    cwt_per_ticks = 15'h00C8;
      3'h2:    cwt_per_ticks = 15'h01F4;
      3'h3:    cwt_per_ticks = 15'h03E8;
      3'h4:    cwt_per_ticks = 15'h07D0;
      3'h5:    cwt_per_ticks = 15'h1388;
      3'h6:    cwt_per_ticks = 15'h2710;
      default: cwt_per_ticks = 15'h4E20;
    endcase
  endfunction
endpackage

// *** verilog/cwt_cyc_timer.sv ***
// One cyclic timer: period counter in ticks with an on phase at each start
`timescale 1ns/1ps
`default_nettype none
module cwt_cyc_timer
  import cwt_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         nrst,
  // Control
  input  wire logic         clr,
  input  wire logic         start,
  input  wire logic         tick,
  input  wire cwt_tmr_cfg_s cfg,
  // Status
  output logic              active,
  output logic              cycle_start
);
  logic        run_reg;
  logic [14:0] cnt_reg;
  logic [14:0] on_t;
  logic [14:0] per_t;

  assign on_t   = cwt_on_ticks(cfg.on_code);
  assign per_t  = cwt_per_ticks(cfg.per_code);
  assign active = run_reg && (cnt_reg < on_t);

  // Period counter; a start pulse realigns to a fresh period
  always_ff @(posedge clk) begin
    if (!nrst || clr || on_t == 15'h0000) begin
      run_reg <= 1'b0;
      cnt_reg <= 15'h0000;
    end else if (start || !run_reg) begin
      run_reg <= 1'b1;
      cnt_reg <= 15'h0000;
    end else if (tick) begin
      if (cnt_reg + 15'h0001 >= per_t) begin
        cnt_reg <= 15'h0000;
      end else begin
        cnt_reg <= cnt_reg + 15'h0001;
      end
    end
  end

  // Pulse once at the head of every period
  always_ff @(posedge clk) begin
    if (!nrst || clr || on_t == 15'h0000) begin
      cycle_start <= 1'b0;
    end else begin
      cycle_start <= start || !run_reg || (tick && cnt_reg + 15'h0001 >= per_t);
    end
  end

  // A new period code lands in the same cycle as the start pulse that realigns the count
  a_period_wrap: assert property (@(posedge clk) disable iff (!nrst)
    run_reg && !start |-> cnt_reg < per_t)
    else $error("timer count passed its period");
endmodule
`default_nettype wire

// *** verilog/cwt_top.sv ***
// Cyclic wake timers and interrupt enable mask with pulsed interrupt output
`timescale 1ns/1ps
`default_nettype none
module cwt_top
  import cwt_pkg::*;
#(
  parameter int TICK_CYCLES     = CWT_TICK_CYCLES,
  parameter int PERIODIC_CYCLES = CWT_PERIODIC_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        soft_reset,
  input  wire logic        restart,
  // Register port from the serial frame decoder
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [6:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // Event pulses from status logic and pending level
  input  wire cwt_evt_s    evt,
  input  wire logic        irq_pending,
  // Outputs
  output logic             irq_out_n,
  output logic             first_timer_active,
  output logic             second_timer_active,
  output logic             cyclic_wake_evt,
  output logic             devmode_watchdog_off
);
  localparam int PER_W = $clog2(PERIODIC_CYCLES + 1);
  localparam int TCK_W = $clog2(TICK_CYCLES + 1);

  logic [15:0]      tctrl_reg;
  logic [15:0]      irq_mask_reg;
  logic [TCK_W-1:0] tick_cnt_reg;
  logic [PER_W-1:0] per_cnt_reg;
  logic [7:0]       irq_cnt_reg;
  logic [7:0]       irq_cnt_next;
  logic             tick;
  logic             wr_tctrl;
  logic             wr_mask;
  logic             evt_hit;
  logic             per_fire;
  logic             t1_act;
  logic             t2_act;
  logic             t1_start;
  logic             t2_start;
  logic             t1_go;
  logic             t2_go;
  cwt_tmr_cfg_s     t1_cfg;
  cwt_tmr_cfg_s     t2_cfg;
  cwt_wake_e        wake_sel;

  // Address decode of the register port
  always_comb begin
    wr_tctrl = 1'b0;
    wr_mask  = 1'b0;
    if (reg_wr && reg_addr == CWT_ADDR_TCTRL) begin
      wr_tctrl = 1'b1;
    end else if (reg_wr && reg_addr == CWT_ADDR_MASK) begin
      wr_mask = 1'b1;
    end
  end

  assign t1_cfg   = '{on_code:  tctrl_reg[CWT_T1_ON_LSB+:3],
                      per_code: tctrl_reg[CWT_T1_PER_LSB+:3]};
  assign t2_cfg   = '{on_code:  tctrl_reg[CWT_T2_ON_LSB+:3],
                      per_code: tctrl_reg[CWT_T2_PER_LSB+:3]};
  assign wake_sel = cwt_wake_e'(tctrl_reg[CWT_WAKE_LSB+:2]);

  // Start a timer the cycle after a non-off on-time is written
  always_ff @(posedge clk) begin
    if (!nrst) begin
      t1_go <= 1'b0;
      t2_go <= 1'b0;
    end else begin
      t1_go <= wr_tctrl && reg_wdata[CWT_T1_ON_LSB+:3] != 3'h0;
      t2_go <= wr_tctrl && reg_wdata[CWT_T2_ON_LSB+:3] != 3'h0;
    end
  end

  // Timer register; every reset source clears it
  always_ff @(posedge clk) begin
    if (!nrst || soft_reset || restart) begin
      tctrl_reg <= CWT_TCTRL_RST;
    end else if (wr_tctrl) begin
      tctrl_reg <= reg_wdata & CWT_TCTRL_RMASK;
    end
  end

  // Mask register; restart keeps the host's setting
  always_ff @(posedge clk) begin
    if (!nrst || soft_reset) begin
      irq_mask_reg <= CWT_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= reg_wdata & CWT_MASK_RMASK;
    end
  end

  // Read data; held until the next read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == CWT_ADDR_TCTRL) begin
        reg_rdata <= tctrl_reg & CWT_TCTRL_RMASK;
      end else if (reg_addr == CWT_ADDR_MASK) begin
        reg_rdata <= irq_mask_reg & CWT_MASK_RMASK;
      end else begin
        reg_rdata <= 16'h0000; // Other addresses belong elsewhere
      end
    end
  end

  // 0.1 ms tick prescaler shared by both timers
  always_ff @(posedge clk) begin
    if (!nrst || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TCK_W'(1);
    end
  end
  assign tick = (tick_cnt_reg == TCK_W'(TICK_CYCLES - 1));

  cwt_cyc_timer u_t1 (
    .clk         (clk),
    .nrst        (nrst),
    .clr         (soft_reset || restart),
    .start       (t1_go),
    .tick        (tick),
    .cfg         (t1_cfg),
    .active      (t1_act),
    .cycle_start (t1_start)
  );

  cwt_cyc_timer u_t2 (
    .clk         (clk),
    .nrst        (nrst),
    .clr         (soft_reset || restart),
    .start       (t2_go),
    .tick        (tick),
    .cfg         (t2_cfg),
    .active      (t2_act),
    .cycle_start (t2_start)
  );

  // Registered timer outputs and the selected wake source
  always_ff @(posedge clk) begin
    if (!nrst) begin
      first_timer_active  <= 1'b0;
      second_timer_active <= 1'b0;
      cyclic_wake_evt     <= 1'b0;
    end else begin
      first_timer_active  <= t1_act;
      second_timer_active <= t2_act;
      case (wake_sel)
        CWT_WAKE_T1: cyclic_wake_evt <= t1_start;
        CWT_WAKE_T2: cyclic_wake_evt <= t2_start;
        default:     cyclic_wake_evt <= 1'b0;     // Reserved code acts as none
      endcase
    end
  end

  // Watchdog disable in development mode follows mask bit 7
  always_ff @(posedge clk) begin
    if (!nrst) begin
      devmode_watchdog_off <= 1'b0;
    end else begin
      devmode_watchdog_off <= irq_mask_reg[CWT_M_WDOFF];
    end
  end

  // Gate each event pulse by its mask bit; no status history is consulted
  assign evt_hit = (evt.wd_fail && irq_mask_reg[CWT_M_WDFAIL])
                || ((evt.frame_fail || evt.crc_fail) && irq_mask_reg[CWT_M_FRAME])
                || (evt.bridge && irq_mask_reg[CWT_M_BRIDGE])
                || (evt.temp && irq_mask_reg[CWT_M_TEMP])
                || (evt.supply && irq_mask_reg[CWT_M_SUPPLY]);

  // Repeat interval while interrupts stay pending
  always_ff @(posedge clk) begin
    if (!nrst || !(irq_pending && irq_mask_reg[CWT_M_PERIODIC])) begin
      per_cnt_reg <= '0;
    end else if (per_fire) begin
      per_cnt_reg <= '0;
    end else begin
      per_cnt_reg <= per_cnt_reg + PER_W'(1);
    end
  end
  assign per_fire = irq_pending && irq_mask_reg[CWT_M_PERIODIC]
                 && per_cnt_reg == PER_W'(PERIODIC_CYCLES - 1);

  // Pulse stretcher; a new event restarts the low phase
  always_comb begin
    irq_cnt_next = irq_cnt_reg;
    if (evt_hit || per_fire) begin
      irq_cnt_next = 8'(CWT_IRQ_PULSE_CYC);
    end else if (irq_cnt_reg != 8'h00) begin
      irq_cnt_next = irq_cnt_reg - 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_cnt_reg <= 8'h00;
      irq_out_n   <= 1'b1;
    end else begin
      irq_cnt_reg <= irq_cnt_next;
      irq_out_n   <= (irq_cnt_next == 8'h00);
    end
  end

  sequence s_t1_write;
    reg_wr && reg_addr == CWT_ADDR_TCTRL && reg_wdata[6:4] inside {[3'h1:3'h5]};
  endsequence
  sequence s_t1_on;
    ##[1:3] first_timer_active;
  endsequence

  a_timer_start: assert property (
    @(posedge clk) disable iff (!nrst || soft_reset || restart)
    s_t1_write |-> s_t1_on)
    else $error("first timer did not start after on-time write");
  a_tctrl_clear: assert property (@(posedge clk) disable iff (!nrst)
    (soft_reset || restart) |=> tctrl_reg == 16'h0000)
    else $error("timer register not cleared by reset");
  a_mask_reset: assert property (@(posedge clk) disable iff (!nrst)
    soft_reset |=> irq_mask_reg == 16'h0140)
    else $error("mask register reset value wrong");
  a_tctrl_rsvd: assert property (@(posedge clk) disable iff (!nrst)
    (reg_rd && reg_addr == CWT_ADDR_TCTRL) |=> reg_rdata[12] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("timer reserved bits read nonzero");
  a_mask_rsvd: assert property (@(posedge clk) disable iff (!nrst)
    (reg_rd && reg_addr == CWT_ADDR_MASK) |=> reg_rdata[15:9] == 7'h00)
    else $error("mask reserved bits read nonzero");
  a_bridge_irq: assert property (@(posedge clk) disable iff (!nrst)
    (evt.bridge && irq_mask_reg[4]) |=> !irq_out_n ##1 !irq_out_n)
    else $error("bridge event did not pulse interrupt");
  a_frame_irq: assert property (@(posedge clk) disable iff (!nrst)
    ((evt.frame_fail || evt.crc_fail) && irq_mask_reg[5]) |=> !irq_out_n)
    else $error("frame failure did not pulse interrupt");
  a_wdfail_irq: assert property (@(posedge clk) disable iff (!nrst)
    (evt.wd_fail && irq_mask_reg[6]) |=> !irq_out_n)
    else $error("watchdog failure did not pulse interrupt");
  a_temp_supply: assert property (@(posedge clk) disable iff (!nrst)
    ((evt.temp && irq_mask_reg[1]) || (evt.supply && irq_mask_reg[0])) |=> !irq_out_n)
    else $error("temperature or supply event lost");
  a_irq_quiet: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(!irq_out_n)) |-> $past(evt_hit) || $past(per_fire))
    else $error("interrupt pulse without cause");
  a_wdoff_follow: assert property (@(posedge clk) disable iff (!nrst)
    ##1 devmode_watchdog_off == $past(irq_mask_reg[7]))
    else $error("watchdog off does not follow mask");
  a_wake_select: assert property (@(posedge clk) disable iff (!nrst)
    cyclic_wake_evt |-> $past(tctrl_reg[8:7]) inside {2'b01, 2'b10})
    else $error("wake event with no timer selected");
endmodule
`default_nettype wire

// *** bench/cwt_host_model.sv ***
// Host model: drives the register port the way the microcontroller does
`timescale 1ns/1ps
`default_nettype none
module cwt_host_model
  import cwt_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Register port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [6:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle port at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 7'h00;
    reg_wdata = 16'h0000;
  end

  // One-cycle write; data lines scrambled after release, no stale value
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= (a == CWT_ADDR_MASK) ? (d & 16'hFFF3) : d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~reg_wdata;
  endtask

  // One-cycle read; data taken once the registered answer has landed
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Assign the timer first, then give it its on-time
  task automatic cfg_timer(input logic [15:0] d);
    wr(CWT_ADDR_TCTRL, d & 16'h1F8F);
    wr(CWT_ADDR_TCTRL, d);
  endtask
endmodule
`default_nettype wire

// *** bench/cyclic_wake_timers_irq_mask_tb.sv ***
// Self-checking testbench for the cyclic wake timers and interrupt mask
`timescale 1ns/1ps
`default_nettype none
module cyclic_wake_timers_irq_mask_tb
  import cwt_pkg::*;
();
  localparam int TICK = 4;
  localparam int PER  = 50;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        soft_reset = 1'b0;
  logic        restart = 1'b0;
  logic        reg_wr;
  logic        reg_rd;
  logic [6:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  cwt_evt_s    evt = '0;
  logic        irq_pending = 1'b0;
  logic        irq_out_n;
  logic        first_timer_active;
  logic        second_timer_active;
  logic        cyclic_wake_evt;
  logic        devmode_watchdog_off;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;

  // Clock, 8 ns period
  always #4 clk = ~clk;

  cwt_top #(.TICK_CYCLES(TICK), .PERIODIC_CYCLES(PER)) dut_u (
    .clk(clk), .nrst(nrst), .soft_reset(soft_reset), .restart(restart),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .evt(evt), .irq_pending(irq_pending), .irq_out_n(irq_out_n),
    .first_timer_active(first_timer_active), .second_timer_active(second_timer_active),
    .cyclic_wake_evt(cyclic_wake_evt), .devmode_watchdog_off(devmode_watchdog_off)
  );

  cwt_host_model host_u (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
  );

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Hang guard, generous against the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: sig = ~irq_out_n;
      1: sig = first_timer_active;
      2: sig = second_timer_active;
      default: sig = cyclic_wake_evt;
    endcase
  endfunction

  // Edges counted while a watched output holds a level; unknown stops it
  task automatic run(input int k, input logic lvl, input int lim, output int n);
    n = 0;
    while (n < lim && sig(k) === lvl) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic fire(input logic [5:0] v, output int n);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= '0;
    #1;
    run(0, 1'b1, 300, n);
  endtask

  task automatic t_regs();
    logic [15:0] d;
    host_u.rd(CWT_ADDR_TCTRL, d);
    chk("tctrl_rst", d, 16'h0000);
    host_u.rd(CWT_ADDR_MASK, d);
    chk("mask_rst", d, 16'h0140);
    host_u.wr(CWT_ADDR_TCTRL, 16'hFFFF);
    host_u.rd(CWT_ADDR_TCTRL, d);
    chk("tctrl_ro", d, 16'hEFF7);
    host_u.wr(CWT_ADDR_MASK, 16'hFFFF);
    host_u.rd(CWT_ADDR_MASK, d);
    chk("mask_ro", d, 16'h01F3);
    chk("wd_off", devmode_watchdog_off, 16'h0001);
    host_u.rd(7'h07, d);
    chk("unmapped", d, 16'h0000);
    host_u.wr(CWT_ADDR_MASK, 16'h0000);
    host_u.rd(CWT_ADDR_MASK, d);
    chk("wd_on", devmode_watchdog_off, 16'h0000);
    // Restart clears timers only, soft reset returns both to reset values
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    host_u.rd(CWT_ADDR_TCTRL, d);
    chk("tctrl_restart", d, 16'h0000);
    host_u.rd(CWT_ADDR_MASK, d);
    chk("mask_restart", d, 16'h0000);
    host_u.wr(CWT_ADDR_TCTRL, 16'h0011);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    host_u.rd(CWT_ADDR_TCTRL, d);
    chk("tctrl_soft", d, 16'h0000);
    host_u.rd(CWT_ADDR_MASK, d);
    chk("mask_soft", d, 16'h0140);
  endtask

  // Each event alone, enabled twice in a row, then with its own bit cleared
  task automatic t_events();
    int mb[6] = '{0, 1, 4, 5, 5, 6};
    int n;
    for (int i = 0; i < 6; i++) begin
      host_u.wr(CWT_ADDR_MASK, 16'h0073);
      repeat (2) begin
        fire(6'h01 << i, n);
        chk("irq_width", n, 125);
      end
      host_u.wr(CWT_ADDR_MASK, 16'h0073 & ~(16'h0001 << mb[i]));
      fire(6'h01 << i, n);
      chk("irq_masked", n, 0);
    end
  endtask

  task automatic t_periodic();
    int n;
    host_u.wr(CWT_ADDR_MASK, 16'h0100);
    @(posedge clk);
    irq_pending <= 1'b1;
    #1;
    run(0, 1'b0, 200, n);
    chk("periodic_on", (n >= PER - 2) && (n <= PER + 2), 16'h0001);
    host_u.wr(CWT_ADDR_MASK, 16'h0000);
    #1;
    run(0, 1'b1, 300, n);
    run(0, 1'b0, 200, n);
    chk("periodic_off", n, 200);
    @(posedge clk);
    irq_pending <= 1'b0;
  endtask

  // Start latency, wake pulse spacing and full on-phase length
  task automatic t_timer(input logic [15:0] v, input int k, input int per, input int on);
    int n;
    int m;
    host_u.cfg_timer(v);
    #1;
    run(k, 1'b0, 4, n);
    chk("start", n <= 3, 16'h0001);
    run(3, 1'b0, 1000, n);
    run(3, 1'b1, 5, m);
    // First period starts off the tick grid and may run short, so time the second
    run(3, 1'b0, 1000, n);
    run(3, 1'b1, 5, m);
    run(3, 1'b0, 1000, n);
    chk("period", n + m, per);
    run(k, 1'b1, 1000, n);
    run(k, 1'b0, 1000, n);
    run(k, 1'b1, 1000, n);
    chk("on_time", n, on);
  endtask

  task automatic t_nowake();
    logic [15:0] v[2] = '{16'h0010, 16'h0190};
    int n;
    foreach (v[i]) begin
      host_u.cfg_timer(v[i]);
      #1;
      run(3, 1'b0, 500, n);
      chk("no_wake", n, 500);
    end
  endtask

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_events();
    t_periodic();
    t_timer(16'h00A0, 1, 100 * TICK, 3 * TICK);
    t_timer(16'h6300, 2, 200 * TICK, 10 * TICK);
    t_nowake();
    test_done();
  end
endmodule
`default_nettype wire
